/* File: rtl/pemux_pkg.sv */
// package for the port e alternate function override logic
// Functional notes
// - clock pin is output when its direction bit is set, input otherwise.
// - external clock function acts only in synchronous serial mode.
// - enabled receiver forces the receive pin to input.
// - forced receive input gets pull-up when its output bit is one.
// - pins 0, 1 and 2 are pin-change sources with matching numbers.
// - pins 7..4 input enable forced by mask and group; 5,4 also by start.
// - clock-output fuse forces pin 7 output driving the i/o clock, pull-up untouched.
// - two-wire pin 5: pull-up off, drive 0 when direction set and data or port low.
// - two-wire pin 4: pull-up off, drive 0 when direction set and hold or port low; toggle by strobe.
// - port strobes shared per port, clock sleep pull-up disable shared; rest per pin.
package pemux_pkg;
	localparam int unsigned NUM_PINS        = 8;
	localparam int unsigned PIN_SER_RX      = 0;
	localparam int unsigned PIN_SER_TX      = 1;
	localparam int unsigned PIN_EXT_CLK     = 2;
	localparam int unsigned PIN_SCL         = 4;
	localparam int unsigned PIN_SDA         = 5;
	localparam int unsigned PIN_DO          = 6;
	localparam int unsigned PIN_CKO         = 7;
	localparam int unsigned NUM_PC_SRC      = 3;
	localparam int unsigned PIN_CHG_MASK_LO = 4;
	localparam logic [7:0]  RST_VAL         = 8'h00;
endpackage

/* File: rtl/pemux_sel.sv */
// override selector for a pin vector
`timescale 1ns/1ps
module pemux_sel #(
	parameter int unsigned W = 8
) (
	input  wire logic [W-1:0] norm_i,
	input  wire logic [W-1:0] oe_i,
	input  wire logic [W-1:0] ov_i,
	output logic      [W-1:0] res_o
);
	if (W < 1) begin : g_w_chk
		$error("width must be positive");
	end
	assign res_o = (oe_i & ov_i) | (~oe_i & norm_i);
endmodule

/* File: rtl/pemux_top.sv */
// port e alternate function override mux
`timescale 1ns/1ps
module pemux_top #(
	parameter int unsigned NPIN = pemux_pkg::NUM_PINS
) (
	input  wire logic            clk_i,
	input  wire logic            rstn_i,
	input  wire logic [NPIN-1:0] port_out_i,
	input  wire logic [NPIN-1:0] port_dir_i,
	input  wire logic [NPIN-1:0] pullup_norm_i,
	input  wire logic [NPIN-1:0] input_en_norm_i,
	input  wire logic [NPIN-1:0] pin_change_mask_bit_i,
	input  wire logic            pin_change_group_enable_i,
	input  wire logic            global_pullup_disable_i,
	input  wire logic            sync_mode_i,
	input  wire logic            rx_enable_i,
	input  wire logic            serial_start_cond_int_enable_i,
	input  wire logic            serial_toggle_clock_strobe_i,
	input  wire logic            two_wire_mode_active_i,
	input  wire logic            three_wire_mode_active_i,
	input  wire logic            clock_hold_low_i,
	input  wire logic            serial_data_out_i,
	input  wire logic            clock_output_fuse_i,
	input  wire logic            io_clk_level_i,
	input  wire logic [NPIN-1:0] pin_level_i,
	output logic      [NPIN-1:0] pad_dir_o,
	output logic      [NPIN-1:0] pad_out_o,
	output logic      [NPIN-1:0] pad_pullup_o,
	output logic      [NPIN-1:0] pad_input_en_o,
	output logic      [NPIN-1:0] toggle_sel_o,
	output logic                 sync_serial_ext_clock_drv_o,
	output logic                 sync_serial_ext_clock_in_o,
	output logic      [2:0]      pin_change_src_o
);
	// the override table is laid out for exactly one eight-pin port
	if (NPIN != pemux_pkg::NUM_PINS) begin : g_npin_chk
		$error("port must have eight pins");
	end

	// open-drain enable: drive low while direction is set and either source is low
	function automatic logic od_drive_en(input logic src_a, input logic src_b,
		input logic dir);
		return ~(src_a & src_b) & dir;
	endfunction

	// per-pin override enables and values
	logic [NPIN-1:0] pullup_override_enable;
	logic [NPIN-1:0] pullup_override_value;
	logic [NPIN-1:0] direction_override_enable;
	logic [NPIN-1:0] direction_override_value;
	logic [NPIN-1:0] port_value_override_enable;
	logic [NPIN-1:0] port_value_override_value;
	logic [NPIN-1:0] input_enable_override_enable;
	logic [NPIN-1:0] input_enable_override_value;
	logic [NPIN-1:0] dir_c, out_c, pu_c, ie_c;
	logic [NPIN-1:0] dir_d, out_d, pu_d, ie_d, tog_d;
	logic [NPIN-1:0] dir_q, out_q, pu_q, ie_q, tog_q;
	logic            ext_clk_drv_d, ext_clk_in_d, ext_clk_drv_q, ext_clk_in_q;
	logic            ext_clk_act;
	logic [pemux_pkg::NUM_PC_SRC-1:0] pc_d, pc_q;

	always_comb begin
		pullup_override_enable       = '0;
		pullup_override_value        = '0;
		direction_override_enable    = '0;
		direction_override_value     = '0;
		port_value_override_enable   = '0;
		port_value_override_value    = '0;
		input_enable_override_enable = '0;
		input_enable_override_value  = '0;
		tog_d                        = '0;
		// receiver forces input, pull-up follows output bit
		direction_override_enable[pemux_pkg::PIN_SER_RX] = rx_enable_i;
		pullup_override_enable[pemux_pkg::PIN_SER_RX]    = rx_enable_i;
		pullup_override_value[pemux_pkg::PIN_SER_RX]     =
			port_out_i[pemux_pkg::PIN_SER_RX];
		// clock output on pin 7, pull-up left alone
		direction_override_enable[pemux_pkg::PIN_CKO]  = clock_output_fuse_i;
		direction_override_value[pemux_pkg::PIN_CKO]   = 1'b1;
		port_value_override_enable[pemux_pkg::PIN_CKO] = clock_output_fuse_i;
		port_value_override_value[pemux_pkg::PIN_CKO]  = io_clk_level_i;
		// three-wire data out, direction left to its own bit
		port_value_override_enable[pemux_pkg::PIN_DO] = three_wire_mode_active_i;
		port_value_override_value[pemux_pkg::PIN_DO]  = serial_data_out_i;
		// two-wire data pin: open drain low, pull-up and value overrides stay 0
		pullup_override_enable[pemux_pkg::PIN_SDA]    = two_wire_mode_active_i;
		direction_override_enable[pemux_pkg::PIN_SDA] = two_wire_mode_active_i;
		direction_override_value[pemux_pkg::PIN_SDA]  = od_drive_en(serial_data_out_i,
			port_out_i[pemux_pkg::PIN_SDA], port_dir_i[pemux_pkg::PIN_SDA]);
		port_value_override_enable[pemux_pkg::PIN_SDA] =
			two_wire_mode_active_i & port_dir_i[pemux_pkg::PIN_SDA];
		// two-wire clock pin: open drain low, toggle by strobe
		pullup_override_enable[pemux_pkg::PIN_SCL]    = two_wire_mode_active_i;
		direction_override_enable[pemux_pkg::PIN_SCL] = two_wire_mode_active_i;
		direction_override_value[pemux_pkg::PIN_SCL]  = od_drive_en(clock_hold_low_i,
			port_out_i[pemux_pkg::PIN_SCL], port_dir_i[pemux_pkg::PIN_SCL]);
		port_value_override_enable[pemux_pkg::PIN_SCL] =
			two_wire_mode_active_i & port_dir_i[pemux_pkg::PIN_SCL];
		tog_d[pemux_pkg::PIN_SCL] = serial_toggle_clock_strobe_i;
		// input enables for pin-change and start detect
		for (int i = pemux_pkg::PIN_CHG_MASK_LO; i < NPIN; i++) begin
			input_enable_override_enable[i] =
				pin_change_mask_bit_i[i] & pin_change_group_enable_i;
			input_enable_override_value[i]  = 1'b1;
		end
		if (serial_start_cond_int_enable_i) begin
			input_enable_override_enable[pemux_pkg::PIN_SDA] = 1'b1;
			input_enable_override_enable[pemux_pkg::PIN_SCL] = 1'b1;
		end
	end

	// normal pull-up gated by the shared disable
	assign pu_c = pullup_norm_i & ~{NPIN{global_pullup_disable_i}};

	pemux_sel #(
		.W(NPIN)
	) u_dir (
		.norm_i(port_dir_i),
		.oe_i  (direction_override_enable),
		.ov_i  (direction_override_value),
		.res_o (dir_c)
	);

	pemux_sel #(
		.W(NPIN)
	) u_out (
		.norm_i(port_out_i),
		.oe_i  (port_value_override_enable),
		.ov_i  (port_value_override_value),
		.res_o (out_c)
	);

	pemux_sel #(
		.W(NPIN)
	) u_pu (
		.norm_i(pu_c),
		.oe_i  (pullup_override_enable),
		.ov_i  (pullup_override_value),
		.res_o (pu_d)
	);

	pemux_sel #(
		.W(NPIN)
	) u_ie (
		.norm_i(input_en_norm_i),
		.oe_i  (input_enable_override_enable),
		.ov_i  (input_enable_override_value),
		.res_o (ie_c)
	);

	always_comb begin
		dir_d         = dir_c;
		out_d         = out_c;
		ie_d          = ie_c;
		ext_clk_act   = sync_mode_i;
		ext_clk_drv_d = ext_clk_act & port_dir_i[pemux_pkg::PIN_EXT_CLK];
		ext_clk_in_d  = ext_clk_act & ~port_dir_i[pemux_pkg::PIN_EXT_CLK]
			& pin_level_i[pemux_pkg::PIN_EXT_CLK];
		pc_d          = pin_level_i[pemux_pkg::NUM_PC_SRC-1:0];
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			dir_q         <= pemux_pkg::RST_VAL;
			out_q         <= pemux_pkg::RST_VAL;
			pu_q          <= pemux_pkg::RST_VAL;
			ie_q          <= pemux_pkg::RST_VAL;
			tog_q         <= pemux_pkg::RST_VAL;
			ext_clk_drv_q <= 1'b0;
			ext_clk_in_q  <= 1'b0;
			pc_q          <= '0;
		end else begin
			dir_q         <= dir_d;
			out_q         <= out_d;
			pu_q          <= pu_d;
			ie_q          <= ie_d;
			tog_q         <= tog_d;
			ext_clk_drv_q <= ext_clk_drv_d;
			ext_clk_in_q  <= ext_clk_in_d;
			pc_q          <= pc_d;
		end
	end

	assign pad_dir_o                   = dir_q;
	assign pad_out_o                   = out_q;
	assign pad_pullup_o                = pu_q;
	assign pad_input_en_o              = ie_q;
	assign toggle_sel_o                = tog_q;
	assign sync_serial_ext_clock_drv_o = ext_clk_drv_q;
	assign sync_serial_ext_clock_in_o  = ext_clk_in_q;
	assign pin_change_src_o            = pc_q;

	// open-drain requests on the two-wire pins
	sequence sda_drive_req_s;
		two_wire_mode_active_i && port_dir_i[pemux_pkg::PIN_SDA];
	endsequence
	sequence scl_drive_req_s;
		two_wire_mode_active_i && port_dir_i[pemux_pkg::PIN_SCL];
	endsequence

	rx_input_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rx_enable_i |=> !pad_dir_o[pemux_pkg::PIN_SER_RX])
		else $error("receive pin not input");
	rx_pull_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rx_enable_i |=> pad_pullup_o[pemux_pkg::PIN_SER_RX] == $past(port_out_i[0]))
		else $error("receive pin pull-up wrong");
	cko_pin_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		clock_output_fuse_i |=> pad_dir_o[pemux_pkg::PIN_CKO]
			&& pad_out_o[pemux_pkg::PIN_CKO] == $past(io_clk_level_i))
		else $error("clock out pin wrong");
	cko_pull_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		clock_output_fuse_i |=> pad_pullup_o[pemux_pkg::PIN_CKO]
			== ($past(pullup_norm_i[7]) && !$past(global_pullup_disable_i)))
		else $error("clock out pin pull-up overridden");
	sda_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		sda_drive_req_s |=> !pad_out_o[pemux_pkg::PIN_SDA]
			&& !pad_pullup_o[pemux_pkg::PIN_SDA])
		else $error("data pin drive wrong");
	sda_dir_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		sda_drive_req_s |=> pad_dir_o[pemux_pkg::PIN_SDA]
			== !($past(serial_data_out_i) && $past(port_out_i[5])))
		else $error("data pin enable wrong");
	scl_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		scl_drive_req_s ##0 !clock_hold_low_i |=> pad_dir_o[pemux_pkg::PIN_SCL]
			&& !pad_out_o[pemux_pkg::PIN_SCL])
		else $error("clock pin drive wrong");
	scl_toggle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		1'b1 |=> toggle_sel_o[pemux_pkg::PIN_SCL] == $past(serial_toggle_clock_strobe_i))
		else $error("toggle override wrong");
	do_value_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		three_wire_mode_active_i |=> pad_out_o[pemux_pkg::PIN_DO] == $past(serial_data_out_i))
		else $error("data out value wrong");
	ie_start_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		serial_start_cond_int_enable_i |=> pad_input_en_o[pemux_pkg::PIN_SDA]
			&& pad_input_en_o[pemux_pkg::PIN_SCL])
		else $error("start input enable wrong");
	ie_mask_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		pin_change_mask_bit_i[pemux_pkg::PIN_CKO] && pin_change_group_enable_i
			|=> pad_input_en_o[pemux_pkg::PIN_CKO])
		else $error("mask input enable wrong");
	ext_clk_mode_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!sync_mode_i |=> !sync_serial_ext_clock_drv_o && !sync_serial_ext_clock_in_o)
		else $error("external clock active outside sync mode");
	ext_clk_dir_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		sync_mode_i |=> sync_serial_ext_clock_drv_o == $past(port_dir_i[2]))
		else $error("external clock direction wrong");
	pc_src_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		1'b1 |=> pin_change_src_o == $past(pin_level_i[2:0]))
		else $error("pin change source wrong");
	pass_pin_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		1'b1 |=> pad_dir_o[pemux_pkg::PIN_SER_TX] == $past(port_dir_i[1])
			&& pad_out_o[pemux_pkg::PIN_SER_TX] == $past(port_out_i[1]))
		else $error("plain pin not passed through");
	pu_disable_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		global_pullup_disable_i |=> !pad_pullup_o[pemux_pkg::PIN_SER_TX])
		else $error("shared pull-up disable ignored");
endmodule

/* File: tb/pemux_periph.sv */
// far-side model: serial unit, i/o clock and clock-hold source
`timescale 1ns/1ps
module pemux_periph (
	input  wire logic clk_i,
	output logic      io_clk_level_o,
	output logic      serial_data_out_o,
	output logic      clock_hold_low_o,
	output logic      toggle_strobe_o
);
	logic [7:0] lfsr_q = 8'hA5;
	logic       clk_q  = 1'b0;
	// peripheral outputs change just after the falling edge
	always @(negedge clk_i) begin
		clk_q <= ~clk_q;
		lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
	end
	assign io_clk_level_o    = clk_q;
	assign serial_data_out_o = lfsr_q[0];
	assign clock_hold_low_o  = lfsr_q[3];
	assign toggle_strobe_o   = lfsr_q[6];
endmodule

/* File: tb/pemux_top_bench.sv */
// self-checking bench for the port e override mux
`timescale 1ns/1ps
module pemux_top_bench;
	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [7:0]  po = 8'h00, pd = 8'h00, pu = 8'h00, ie = 8'h00, pm = 8'h00, pl = 8'h00;
	logic [7:0]  ctl = 8'h00;
	logic        ioclk, sdo, hold, stb;
	logic [7:0]  pad_dir_o, pad_out_o, pad_pullup_o, pad_input_en_o, toggle_sel_o;
	logic        ext_clk_drv, ext_clk_in;
	logic [2:0]  pin_change_src_o;
	logic [44:0] x;
	int          error_cnt = 0, checked = 0, seed = 32'hd2e13fa0;
	always #20 clk_i = ~clk_i;
	pemux_periph peri (.clk_i(clk_i), .io_clk_level_o(ioclk), .serial_data_out_o(sdo),
		.clock_hold_low_o(hold), .toggle_strobe_o(stb));
	pemux_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .port_out_i(po), .port_dir_i(pd),
		.pullup_norm_i(pu), .input_en_norm_i(ie), .pin_change_mask_bit_i(pm),
		.pin_change_group_enable_i(ctl[7]), .global_pullup_disable_i(ctl[6]),
		.sync_mode_i(ctl[5]), .rx_enable_i(ctl[4]), .serial_start_cond_int_enable_i(ctl[3]),
		.serial_toggle_clock_strobe_i(stb), .two_wire_mode_active_i(ctl[2]),
		.three_wire_mode_active_i(ctl[1]), .clock_hold_low_i(hold), .serial_data_out_i(sdo),
		.clock_output_fuse_i(ctl[0]), .io_clk_level_i(ioclk), .pin_level_i(pl),
		.pad_dir_o(pad_dir_o), .pad_out_o(pad_out_o), .pad_pullup_o(pad_pullup_o),
		.pad_input_en_o(pad_input_en_o), .toggle_sel_o(toggle_sel_o),
		.sync_serial_ext_clock_drv_o(ext_clk_drv),
		.sync_serial_ext_clock_in_o(ext_clk_in),
		.pin_change_src_o(pin_change_src_o));
	function automatic logic [44:0] model();
		logic [7:0] d, o, p, e, t;
		d = pd; o = po; p = pu & ~{8{ctl[6]}}; e = ie; t = 8'h00;
		if (ctl[4]) begin
			d[0] = 1'b0;
			p[0] = po[0];
		end
		if (ctl[2]) begin
			d[5] = pd[5] & (~sdo | ~po[5]);
			d[4] = pd[4] & (~hold | ~po[4]);
			p[5:4] = 2'b00;
			if (pd[5]) o[5] = 1'b0;
			if (pd[4]) o[4] = 1'b0;
		end
		if (ctl[1]) o[6] = sdo;
		if (ctl[0]) begin
			d[7] = 1'b1;
			o[7] = ioclk;
		end
		for (int k = 4; k < 8; k++) if (pm[k] & ctl[7]) e[k] = 1'b1;
		if (ctl[3]) e[5:4] = 2'b11;
		t[4] = stb;
		return {d, o, p, e, t, ctl[5] & pd[2], ctl[5] & ~pd[2] & pl[2], pl[2:0]};
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step();
		@(posedge clk_i) x = rstn_i ? model() : 45'h0;
		@(negedge clk_i);
		chk(pad_dir_o, x[44:37]);
		chk(pad_out_o, x[36:29]);
		chk(pad_pullup_o, x[28:21]);
		chk(pad_input_en_o, x[20:13]);
		chk(toggle_sel_o, x[12:5]);
		chk({6'h00, ext_clk_drv, ext_clk_in}, {6'h00, x[4:3]});
		chk({5'h00, pin_change_src_o}, {5'h00, x[2:0]});
	endtask
	task automatic tally_and_finish();
		if (error_cnt == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (8) step();
		for (int i = 0; i < 2000; i++) begin
			rstn_i = (i != 1000);
			{po, pd, pu, ie} = $random(seed);
			{pm, pl, ctl} = 24'($random(seed));
			if (i % 100 == 10) {po, pd, pu, ie, pm, pl, ctl} = {56{1'b1}};
			if (i % 100 == 60) {po, pd, pu, ie, pm, pl, ctl} = 56'h0;
			step();
		end
		tally_and_finish();
	end
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
